// [core/fpu_csr_defs.svh]
// Offsets, field positions, reset values and fixed capability values
// of the FP control and status register bank.
// Assumes inclusion by bare name from the design file and the testbench top.
`ifndef FPU_CSR_DEFS_SVH
`define FPU_CSR_DEFS_SVH

// ----------------------------------------------------------------
// Control register numbers
// ----------------------------------------------------------------
`define CR_IMPL_INFO      5'h00
`define CR_COND_VIEW      5'h19
`define CR_EXC_INFO_VIEW  5'h1A
`define CR_EXC_EN_VIEW    5'h1C
`define CR_CTL_STAT       5'h1F

// ----------------------------------------------------------------
// Main register field positions
// ----------------------------------------------------------------
`define CS_RSEL_LSB   0
`define CS_FLAG_LSB   2
`define CS_EN_LSB     7
`define CS_CAUSE_LSB  12
`define CS_UNIMP_BIT  17
`define CS_FLUSH_NEAR_BIT  21
`define CS_FLUSH_OVR_BIT   22
`define CS_CC0_BIT    23
`define CS_FLUSH_ZERO_BIT  24
`define CS_CCHI_LSB   25

// ----------------------------------------------------------------
// Partial view field positions
// ----------------------------------------------------------------
`define XV_FLAG_LSB   2
`define XV_CAUSE_LSB  12
`define XV_UNIMP_BIT  17
`define EV_RSEL_LSB   0
`define EV_FLUSH_ZERO_BIT  2
`define EV_EN_LSB     7

// ----------------------------------------------------------------
// Implementation register fields
// ----------------------------------------------------------------
`define IR_REV_LSB    0
`define IR_ID_LSB     8
`define IR_S_BIT      16
`define IR_D_BIT      17
`define IR_PAIRED_BIT      18
`define IR_THREE_DIM_BIT   19
`define IR_W_BIT      20
`define IR_L_BIT      21
`define IR_WIDE_UNIT_BIT   22
`define IR_FULL_CONV_BIT   24
// Arbitrary identity values
`define IR_ID_VAL     8'h5A
`define IR_REV_VAL    8'h11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CC        8'h00
`define RST_EXC5      5'h00
`define RST_RSEL      2'h0

`endif

// [core/fpu_csr_pkg.sv]
// Types shared by the FP control and status register bank.
// Assumes the defs header is on the include path.
package fpu_csr_pkg;

  typedef enum logic [1:0] {
    round_nearest_even,
    toward_zero_round,
    toward_plus_round,
    toward_minus_round
  } round_sel_t;

  // V Z O U I, invalid in bit 4
  typedef struct packed {
    logic invalid;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic inexact;
  } exc5_t;

  // Report from the FP datapath at instruction completion
  typedef struct packed {
    logic       done;
    exc5_t      cond;
    logic       denorm_seen;
    logic       is_fma;
    logic       cc_wr;
    logic [2:0] cc_idx;
    logic       cc_val;
  } dp_report_t;

  // Control register access from the integer core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  num;
    logic [31:0] wdata;
  } cr_req_t;

  // Datapath controls and verdicts
  typedef struct packed {
    round_sel_t round_sel;
    logic       flush_operand;
    logic       flush_fma_mid;
    logic       flush_nearest;
    logic       tiny_to_nonzero;
    logic       unimp_trap;
    logic       ieee_trap;
    exc5_t      deliver_default;
  } dp_ctrl_t;

  typedef struct packed {
    logic [7:0]  cond_code_bits;
    logic        flush_zero_all;
    logic        flush_override;
    logic        flush_nearest;
    logic        unimp_flag;
    exc5_t       cause;
    exc5_t       enable;
    exc5_t       flags;
    round_sel_t  round_sel;
    logic [31:0] rdata;
  } csr_state_t;

endpackage

// [core/fpu_control_status_regs.sv]
// FP control and status register bank: implementation register, main
// control/status register and its three partial views.
// Assumes the core and datapath run on ref_clk_i; requests are one-cycle
// strobes from same-clock logic.
`timescale 1ns/1ns
`default_nettype none
`include "fpu_csr_defs.svh"

// Notes on behaviour
// - Main control/status register at number 31 holds every control/status bit.
// - Implementation register at number 0 is read-only capability information.
// - Views at 25, 26, 28 update only their own fields.
// - 25 shows condition codes, 26 cause and flags, 28 enables.
// - All conversions complete; full-convert-range bit reports it.
// - 64-bit, L, W, D, S read supported; three-dim extension and paired-single not.
// - Implementation register carries read-only id and revision fields.
// - Eight condition codes, written by compares, read by branches and moves.
// - Denormal consumed or produced without flush option raises unimplemented trap.
// - Flush override replaces tiny operands and results instead of trapping.
// - Flush-to-zero also replaces tiny intermediates inside fused multiply-add.
// - Flush-to-nearest picks zero or smallest normal, whichever is closer.
// - Without flush-to-nearest, nonzero substitute only under plus/minus rounding.
// - All three flush bits set means no denormal unimplemented trap.
// - Unimplemented flag set when last FP instruction took that trap.
// - Cause, enable and flag fields have five bits each, V Z O U I.
// - Enabled condition traps; disabled condition delivers IEEE default result.
// - Cause field rewritten by each FP instruction to its conditions.
// - Flags are sticky until software writes them to zero.
// - Rounding select 0 nearest, 1 toward zero, 2 toward plus.
// - Nearest mode breaks ties toward even mantissa bit zero.
// - Rounding select 3 rounds toward minus infinity.
module fpu_control_status_regs
  import fpu_csr_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    resetn_i,
  input  wire fpu_csr_pkg::cr_req_t    cr_req_i,
  input  wire fpu_csr_pkg::dp_report_t dp_report_i,
  input  wire logic [2:0]              cc_test_idx_i,
  output logic [31:0]                  cr_rdata_o,
  output logic                         cr_rvalid_o,
  output logic                         cc_test_o,
  output fpu_csr_pkg::dp_ctrl_t        dp_ctrl_o
);
  import fpu_csr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cc;
    logic        flush_zero_all;
    logic        flush_override;
    logic        flush_nearest;
    logic        unimp;
    exc5_t       cause;
    exc5_t       enable;
    exc5_t       flags;
    round_sel_t  rsel;
    logic [31:0] rdata;
    logic        rvalid;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ----------------------------------------------------------------
  // Implementation register, fixed
  // ----------------------------------------------------------------
  function automatic logic [31:0] impl_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`IR_REV_LSB +: 8] = `IR_REV_VAL;
    w[`IR_ID_LSB +: 8]  = `IR_ID_VAL;
    w[`IR_S_BIT]   = 1'b1;
    w[`IR_D_BIT]   = 1'b1;
    w[`IR_W_BIT]   = 1'b1;
    w[`IR_L_BIT]   = 1'b1;
    w[`IR_WIDE_UNIT_BIT] = 1'b1;
    w[`IR_PAIRED_BIT]    = 1'b0;
    w[`IR_THREE_DIM_BIT] = 1'b0;
    w[`IR_FULL_CONV_BIT] = 1'b1;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Main register image
  // ----------------------------------------------------------------
  function automatic logic [31:0] main_word(input regs_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CS_RSEL_LSB +: 2]  = s.rsel;
    w[`CS_FLAG_LSB +: 5]  = s.flags;
    w[`CS_EN_LSB +: 5]    = s.enable;
    w[`CS_CAUSE_LSB +: 5] = s.cause;
    w[`CS_UNIMP_BIT]      = s.unimp;
    w[`CS_FLUSH_NEAR_BIT] = s.flush_nearest;
    w[`CS_FLUSH_OVR_BIT]  = s.flush_override;
    w[`CS_CC0_BIT]        = s.cc[0];
    w[`CS_FLUSH_ZERO_BIT] = s.flush_zero_all;
    w[`CS_CCHI_LSB +: 7]  = s.cc[7:1];
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input regs_t s, input logic [4:0] num);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (num)
      `CR_IMPL_INFO: w = impl_word();
      `CR_CTL_STAT:  w = main_word(s);
      `CR_COND_VIEW: w[7:0] = s.cc;
      `CR_EXC_INFO_VIEW: begin
        w[`XV_FLAG_LSB +: 5]  = s.flags;
        w[`XV_CAUSE_LSB +: 5] = s.cause;
        w[`XV_UNIMP_BIT]      = s.unimp;
      end
      `CR_EXC_EN_VIEW: begin
        w[`EV_RSEL_LSB +: 2] = s.rsel;
        w[`EV_FLUSH_ZERO_BIT] = s.flush_zero_all;
        w[`EV_EN_LSB +: 5]   = s.enable;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Flush decode
  // ----------------------------------------------------------------
  // Either flush option lets the datapath absorb a denormal
  function automatic logic flush_any(input regs_t s);
    return s.flush_zero_all || s.flush_override;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic  denorm_trap;
    logic  [31:0] wd;
    next_r        = r;
    denorm_trap   = 1'b0;
    wd            = cr_req_i.wdata;
    next_r.rvalid = cr_req_i.rd;
    next_r.rdata  = cr_req_i.rd ? read_word(r, cr_req_i.num) : r.rdata;

    // Software writes; partial views touch only their fields
    if (cr_req_i.wr) begin
      case (cr_req_i.num)
        `CR_CTL_STAT: begin
          next_r.rsel   = round_sel_t'(wd[`CS_RSEL_LSB +: 2]);
          next_r.flags  = wd[`CS_FLAG_LSB +: 5];
          next_r.enable = wd[`CS_EN_LSB +: 5];
          next_r.cause  = wd[`CS_CAUSE_LSB +: 5];
          next_r.unimp  = wd[`CS_UNIMP_BIT];
          next_r.flush_nearest  = wd[`CS_FLUSH_NEAR_BIT];
          next_r.flush_override = wd[`CS_FLUSH_OVR_BIT];
          next_r.flush_zero_all = wd[`CS_FLUSH_ZERO_BIT];
          next_r.cc     = {wd[`CS_CCHI_LSB +: 7], wd[`CS_CC0_BIT]};
        end
        `CR_COND_VIEW: next_r.cc = wd[7:0];
        `CR_EXC_INFO_VIEW: begin
          next_r.flags = wd[`XV_FLAG_LSB +: 5];
          next_r.cause = wd[`XV_CAUSE_LSB +: 5];
          next_r.unimp = wd[`XV_UNIMP_BIT];
        end
        `CR_EXC_EN_VIEW: begin
          next_r.rsel   = round_sel_t'(wd[`EV_RSEL_LSB +: 2]);
          next_r.flush_zero_all = wd[`EV_FLUSH_ZERO_BIT];
          next_r.enable = wd[`EV_EN_LSB +: 5];
        end
        default: next_r = next_r;
      endcase
    end

    // Datapath completion wins over a same-cycle software write
    if (dp_report_i.done) begin
      // No flush option set means a denormal cannot be handled
      denorm_trap  = dp_report_i.denorm_seen && !flush_any(r);
      next_r.unimp = denorm_trap;
      next_r.cause = dp_report_i.cond;
      next_r.flags = next_r.flags | dp_report_i.cond;
      if (dp_report_i.cc_wr) begin
        next_r.cc[dp_report_i.cc_idx] = dp_report_i.cc_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r.cc     <= `RST_CC;
      r.flush_zero_all <= 1'b0;
      r.flush_override <= 1'b0;
      r.flush_nearest  <= 1'b0;
      r.unimp  <= 1'b0;
      r.cause  <= `RST_EXC5;
      r.enable <= `RST_EXC5;
      r.flags  <= `RST_EXC5;
      r.rsel   <= round_nearest_even;
      r.rdata  <= 32'h0000_0000;
      r.rvalid <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to core and datapath
  // ----------------------------------------------------------------
  assign cr_rdata_o  = r.rdata;
  assign cr_rvalid_o = r.rvalid;
  assign cc_test_o   = r.cc[cc_test_idx_i];

  always_comb begin
    dp_ctrl_o.round_sel       = r.rsel;
    dp_ctrl_o.flush_operand   = flush_any(r);
    dp_ctrl_o.flush_fma_mid   = r.flush_zero_all;
    dp_ctrl_o.flush_nearest   = r.flush_nearest;
    dp_ctrl_o.tiny_to_nonzero = r.flush_nearest ||
                                (r.rsel == toward_plus_round) ||
                                (r.rsel == toward_minus_round);
    dp_ctrl_o.unimp_trap      = dp_report_i.done && dp_report_i.denorm_seen
                                && !flush_any(r);
    dp_ctrl_o.ieee_trap       = dp_report_i.done &&
                                |(dp_report_i.cond & r.enable);
    dp_ctrl_o.deliver_default = dp_report_i.cond & ~r.enable;
  end

endmodule
`default_nettype wire

// [testbench/fpu_csr_monitor.sv]
// Port checker for the FP control/status register bank.
// Assumes a bind onto the bank, one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module fpu_csr_monitor
  import fpu_csr_pkg::*;
(
  input wire logic                    ref_clk_i,
  input wire logic                    resetn_i,
  input wire fpu_csr_pkg::cr_req_t    cr_req_i,
  input wire fpu_csr_pkg::dp_report_t dp_report_i,
  input wire logic [2:0]              cc_test_idx_i,
  input wire logic [31:0]             cr_rdata_o,
  input wire logic                    cr_rvalid_o,
  input wire logic                    cc_test_o,
  input wire fpu_csr_pkg::dp_ctrl_t   dp_ctrl_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr(n); cr_req_i.wr && cr_req_i.num == n && !dp_report_i.done; endsequence
  sequence s_rd(n); cr_req_i.rd && !cr_req_i.wr && cr_req_i.num == n && !dp_report_i.done; endsequence
  property p_rvalid; cr_req_i.rd |=> cr_rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_impl; s_rd(5'h00) |=> cr_rdata_o[24:16] == 9'h173; endproperty
  a_impl: assert property (p_impl) else $error("capability bits wrong");
  property p_view; s_wr(5'h19) ##2 s_rd(5'h19) |=> cr_rdata_o == {24'h0, $past(cr_req_i.wdata[7:0], 3)}; endproperty
  a_view: assert property (p_view) else $error("code view wrong");
  property p_unimp;
    dp_report_i.done && dp_report_i.denorm_seen |-> dp_ctrl_o.unimp_trap == !dp_ctrl_o.flush_operand;
  endproperty
  a_unimp: assert property (p_unimp) else $error("denormal trap wrong");
  property p_ieee;
    dp_report_i.done |-> dp_ctrl_o.ieee_trap == |(dp_report_i.cond & ~dp_ctrl_o.deliver_default)
      && (dp_ctrl_o.deliver_default & ~dp_report_i.cond) == 5'h00;
  endproperty
  a_ieee: assert property (p_ieee) else $error("trap or default wrong");
  property p_cc;
    dp_report_i.done && dp_report_i.cc_wr && !cr_req_i.wr ##1 cc_test_idx_i == $past(dp_report_i.cc_idx)
      |-> cc_test_o == $past(dp_report_i.cc_val);
  endproperty
  a_cc: assert property (p_cc) else $error("code test wrong");
  property p_rsel;
    s_wr(5'h1C) |=> dp_ctrl_o.round_sel == $past(cr_req_i.wdata[1:0])
      && dp_ctrl_o.flush_fma_mid == $past(cr_req_i.wdata[2]);
  endproperty
  a_rsel: assert property (p_rsel) else $error("enable view write wrong");
  property p_flush;
    s_wr(5'h1F) |=> dp_ctrl_o.flush_nearest == $past(cr_req_i.wdata[21])
      && dp_ctrl_o.flush_operand == ($past(cr_req_i.wdata[24]) || $past(cr_req_i.wdata[22]));
  endproperty
  a_flush: assert property (p_flush) else $error("flush controls wrong");
  property p_tiny;
    dp_ctrl_o.tiny_to_nonzero == (dp_ctrl_o.flush_nearest || dp_ctrl_o.round_sel >= toward_plus_round);
  endproperty
  a_tiny: assert property (p_tiny) else $error("tiny substitute wrong");
endmodule
`default_nettype wire

// [testbench/core_dp_model.sv]
// Integer core and FP datapath model: control register access and
// completion reports. Assumes requests launched on falling edges.
`timescale 1ns/1ns
`default_nettype none
module core_dp_model
  import fpu_csr_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic [31:0]           rdata_i,
  input wire logic                  rvalid_i,
  input wire fpu_csr_pkg::dp_ctrl_t ctrl_i,
  output fpu_csr_pkg::cr_req_t      req_o,
  output fpu_csr_pkg::dp_report_t   rep_o
);
  logic [31:0] rd_val;
  logic        rv;
  logic        trap;
  logic        unimp;
  exc5_t       dflt;
  initial begin
    req_o = '0;
    rep_o = '0;
  end
  // ----------------------------------------
  // Transfers; released lines show inverse
  // ----------------------------------------
  task automatic cr_wr(input logic [4:0] n, input logic [31:0] d);
    @(negedge ref_clk_i);
    req_o = '{1'b0, 1'b1, n, d};
    @(negedge ref_clk_i);
    req_o = '{1'b0, 1'b0, ~n, ~d};
  endtask
  task automatic cr_rd(input logic [4:0] n);
    @(negedge ref_clk_i);
    req_o = '{1'b1, 1'b0, n, req_o.wdata};
    @(negedge ref_clk_i);
    rv = rvalid_i;
    rd_val = rdata_i;
    req_o = '{1'b0, 1'b0, ~n, ~req_o.wdata};
  endtask
  task automatic dp_done(input exc5_t c, input logic dn, input logic cw, input logic [2:0] ci, input logic cv);
    @(negedge ref_clk_i);
    rep_o = '{1'b1, c, dn, 1'b0, cw, ci, cv};
    #40;
    trap = ctrl_i.ieee_trap;
    unimp = ctrl_i.unimp_trap;
    dflt = ctrl_i.deliver_default;
    @(negedge ref_clk_i);
    rep_o = '{1'b0, ~c, ~dn, 1'b0, ~cw, ~ci, ~cv};
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Testbench top: resets the FP register bank and runs the scenarios.
// Assumes core/ on the include path and the model and checker compiled.
`timescale 1ns/1ns
`default_nettype none
`include "fpu_csr_defs.svh"
module tb_top;
  import fpu_csr_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [2:0]  cc_idx = 3'h0;
  logic [31:0] rdata;
  logic        rvalid;
  logic        cc_test;
  cr_req_t     req;
  dp_report_t  rep;
  dp_ctrl_t    ctrl;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  fpu_control_status_regs DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cr_req_i(req),
    .dp_report_i(rep), .cc_test_idx_i(cc_idx), .cr_rdata_o(rdata), .cr_rvalid_o(rvalid),
    .cc_test_o(cc_test), .dp_ctrl_o(ctrl));
  core_dp_model core (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .ctrl_i(ctrl),
    .req_o(req), .rep_o(rep));
  // ----------------------------------------
  // Compare and closing
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] n, input logic [31:0] exp);
    core.cr_rd(n);
    chk1(core.rv, 1'b1);
    chk32(core.rd_val, exp);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_impl();
    logic [31:0] ir;
    ir = {16'h0173, `IR_ID_VAL, `IR_REV_VAL};
    rdc(5'h00, ir);
    core.cr_wr(5'h00, 32'h0000_0000);
    rdc(5'h00, ir);
    $display("t_impl done");
  endtask
  task automatic t_views();
    core.cr_wr(5'h1F, 32'hFFFD_FFFF);
    rdc(5'h1F, 32'hFFE1_FFFF);
    core.cr_wr(5'h19, 32'h0000_0000);
    rdc(5'h19, 32'h0000_0000);
    rdc(5'h1F, 32'h0161_FFFF);
    core.cr_wr(5'h1C, 32'h0000_0000);
    rdc(5'h1C, 32'h0000_0000);
    rdc(5'h1A, 32'h0001_F07C);
    core.cr_wr(5'h1A, 32'h0000_0000);
    rdc(5'h1F, 32'h0060_0000);
    rdc(5'h05, 32'h0000_0000);
    $display("t_views done");
  endtask
  task automatic t_exc();
    core.cr_wr(5'h1F, 32'h0000_0000);
    core.dp_done(5'h10, 1'b0, 1'b0, 3'h0, 1'b0);
    chk1(core.trap, 1'b0);
    core.dp_done(5'h01, 1'b0, 1'b0, 3'h0, 1'b0);
    rdc(5'h1A, 32'h0000_1044);
    core.dp_done(5'h00, 1'b1, 1'b0, 3'h0, 1'b0);
    chk1(core.unimp, 1'b1);
    rdc(5'h1A, 32'h0002_0044);
    core.cr_wr(5'h1F, 32'h0160_0044);
    core.dp_done(5'h00, 1'b1, 1'b0, 3'h0, 1'b0);
    chk1(core.unimp, 1'b0);
    rdc(5'h1A, 32'h0000_0044);
    core.cr_wr(5'h1A, 32'h0000_0000);
    rdc(5'h1A, 32'h0000_0000);
    core.cr_wr(5'h1C, 32'h0000_0800);
    core.dp_done(5'h10, 1'b0, 1'b0, 3'h0, 1'b0);
    chk1(core.trap, 1'b1);
    chk32({27'h0, core.dflt}, 32'h0000_0000);
    core.dp_done(5'h04, 1'b0, 1'b0, 3'h0, 1'b0);
    chk1(core.trap, 1'b0);
    chk32({27'h0, core.dflt}, 32'h0000_0004);
    $display("t_exc done");
  endtask
  task automatic t_cc();
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      cc_idx = 3'(i);
      core.dp_done(5'h00, 1'b0, 1'b1, 3'(i), 1'b1);
      chk1(cc_test, 1'b1);
    end
    rdc(5'h19, 32'h0000_00FF);
    core.dp_done(5'h00, 1'b0, 1'b1, 3'h3, 1'b0);
    rdc(5'h19, 32'h0000_00F7);
    $display("t_cc done");
  endtask
  task automatic t_round();
    core.cr_wr(5'h1F, 32'h0000_0000);
    for (int r = 0; r < 4; r++) begin
      core.cr_wr(5'h1C, 32'(r));
      chk32({30'h0, ctrl.round_sel}, 32'(r));
      chk1(ctrl.tiny_to_nonzero, r >= 2);
    end
    $display("t_round done");
  endtask
  initial begin
    repeat (12) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    t_impl();
    t_views();
    t_exc();
    t_cc();
    t_round();
    test_done();
  end
endmodule
bind fpu_control_status_regs fpu_csr_monitor mon (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .cr_req_i(cr_req_i), .dp_report_i(dp_report_i), .cc_test_idx_i(cc_test_idx_i), .cr_rdata_o(cr_rdata_o),
  .cr_rvalid_o(cr_rvalid_o), .cc_test_o(cc_test_o), .dp_ctrl_o(dp_ctrl_o));
`default_nettype wire
